//--- dv/adcmux_core_model.sv
// Behavioural pipelined converter core answering the control's starts.
`timescale 1ns/1ps
`default_nettype none

module adcmux_core_model (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     rst,
    // Conversion request
    input wire adcmux_pkg::adcmux_conv_t conv,
    // Result back to the control
    output logic                         done,
    output logic [1:0]                   chan,
    output logic [11:0]                  raw
);
    logic [13:0] slot_q [16];
    logic [15:0] busy_q;
    logic [11:0] val;
    int          lat;

    // ========================================================================
    // Pipeline: one new start each cycle, several in flight at once.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_q = 16'h0000;
            done <= 1'b0;
            chan <= 2'h0;
            raw <= 12'h000;
        end else begin
            done <= busy_q[0];
            if (busy_q[0]) begin
                chan <= slot_q[0][13:12];
                raw <= slot_q[0][11:0];
            end else begin
                // Idle lines toggle so a design reading them stale is seen.
                chan <= ~chan;
                raw <= ~raw;
            end
            for (int i = 0; i < 15; i++) slot_q[i] = slot_q[i+1];
            busy_q = busy_q >> 1;
            if (conv.start) begin
                lat = conv.res8 ? 3 : 5;
                if (conv.mode == adcmux_pkg::MODE_DIFFGAIN) lat++;
                while (busy_q[lat] && lat < 15) lat++;
                val = {conv.chan, conv.pos_pin, conv.neg_sel, 3'h0};
                if (conv.mode == adcmux_pkg::MODE_DIFFGAIN) val[2:0] = conv.gain;
                if (conv.res8) val[11:8] = 4'hA;
                slot_q[lat] = {conv.chan, val};
                busy_q[lat] = 1'b1;
            end
        end
    end
endmodule // adcmux_core_model

`default_nettype wire

//--- dv/adcmux_ctrl_properties.sv
// Port-level assertions for the converter control, bound to its top module.
`timescale 1ns/1ps
`default_nettype none

module adcmux_ctrl_properties (
    // Clock and reset
    input wire logic                     CLOCK,
    input wire logic                     RST,
    // Register bus
    input wire logic                     PSEL,
    input wire logic                     PENABLE,
    input wire logic                     PWRITE,
    input wire logic [7:0]               PADDR,
    input wire logic                     PREADY,
    input wire logic                     PSLVERR,
    // Converter side
    input wire logic                     CORE_DONE,
    input wire logic [1:0]               CORE_CHAN,
    input wire adcmux_pkg::adcmux_conv_t CONV,
    input wire logic                     CONV_SIGNED,
    input wire logic [1:0]               CONV_REF,
    input wire logic [3:0]               RESULT_EVENT
);
    // ========================================================================
    // Helpers
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    wire cfg_wr = PSEL && PENABLE && PREADY && PWRITE
                  && (PADDR == adcmux_pkg::OFS_CONFIG);
    wire start_s = CONV.start && CONV_SIGNED;

    // ========================================================================
    // Assertions
    a_diff_neg_low: assert property (
        start_s && CONV.mode == adcmux_pkg::MODE_DIFF |-> CONV.neg_sel < 4'h4)
        else $error("plain differential negative input out of range");
    a_gain_neg_high: assert property (
        start_s && CONV.mode == adcmux_pkg::MODE_DIFFGAIN
        |-> CONV.neg_sel[3:2] == 2'b01)
        else $error("gained differential negative input out of range");
    a_gain_code_range: assert property (
        CONV.start && CONV.mode == adcmux_pkg::MODE_DIFFGAIN
        |-> CONV.gain <= adcmux_pkg::GAIN_MAX)
        else $error("gain code beyond the largest factor");
    a_signed_gnd_neg: assert property (
        start_s && CONV.mode[1] |-> CONV.neg_sel == adcmux_pkg::NEG_GND)
        else $error("signed single or internal input not grounded");
    a_unsigned_half_ref: assert property (
        CONV.start && !CONV_SIGNED |-> CONV.neg_sel == adcmux_pkg::NEG_HALFREF)
        else $error("unsigned negative input not half reference");
    a_done_to_event: assert property (
        CORE_DONE |=> RESULT_EVENT == (4'h1 << $past(CORE_CHAN)))
        else $error("result event missing or on wrong channel");
    a_event_has_cause: assert property (
        RESULT_EVENT != 4'h0 |-> $past(CORE_DONE))
        else $error("result event without a finished conversion");
    a_sign_mode_global: assert property (
        $changed(CONV_SIGNED) |-> $past(cfg_wr))
        else $error("sign mode changed without a config write");
    a_ref_sel_global: assert property (
        $changed(CONV_REF) |-> $past(cfg_wr))
        else $error("reference changed without a config write");
    // Fields must not move under a conversion that the core is still sampling.
    a_fields_hold: assert property (
        !CONV.start |-> $stable(CONV[15:0]))
        else $error("conversion fields changed between starts");

    // ========================================================================
    // Coverage
    c_gain_start: cover property (
        CONV.start && CONV.mode == adcmux_pkg::MODE_DIFFGAIN);
    c_back_done: cover property (CORE_DONE ##1 CORE_DONE);
    c_bus_error: cover property (PREADY && PSLVERR);
endmodule // adcmux_ctrl_properties

bind adcmux_ctrl adcmux_ctrl_properties adcmux_ctrl_properties_inst (
    .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CORE_DONE(CORE_DONE), .CORE_CHAN(CORE_CHAN), .CONV(CONV),
    .CONV_SIGNED(CONV_SIGNED), .CONV_REF(CONV_REF),
    .RESULT_EVENT(RESULT_EVENT)
);

`default_nettype wire

//--- dv/tb_adc_input_mux_result_format.sv
// Self-checking bench for the converter control with a core model.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
    err_total++; $display("mismatch at %0t: got %h expected %h", \
    $time, got, exp); end end

module tb_adc_input_mux_result_format;
    logic                     clk, rst, psel, penable, pwrite, pready;
    logic                     pslverr, core_done, conv_en, conv_signed, e;
    logic [7:0]               paddr;
    logic [31:0]              pwdata, prdata, q;
    logic [3:0]               evt_trig, result_event, starts, evt, exp_done;
    logic [1:0]               core_chan, conv_ref, rf;
    logic [11:0]              core_raw;
    logic [11:0]              mux [4];
    logic [15:0]              exp_r [4];
    logic                     sg, r8, lf;
    adcmux_pkg::adcmux_conv_t conv;
    int                       err_total, num_checks, n;

    adcmux_ctrl adcmux_ctrl_inst (
        .CLOCK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .EVENT_TRIG(evt_trig),
        .CORE_DONE(core_done), .CORE_CHAN(core_chan), .CORE_RAW(core_raw),
        .CONV(conv), .CONV_ENABLE(conv_en), .CONV_SIGNED(conv_signed),
        .CONV_REF(conv_ref), .RESULT_EVENT(result_event));
    adcmux_core_model adcmux_core_model_inst (
        .clk(clk), .rst(rst), .conv(conv), .done(core_done),
        .chan(core_chan), .raw(core_raw));

    // ========================================================================
    // Bus access and expectations
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
        if (k >= 20) `CHK(1'b0, 1'b1)
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    function automatic logic [15:0] exp_res(input logic [11:0] m,
        input logic [1:0] ch, input logic s, input logic b8, input logic l);
        logic [3:0]  ng;
        logic [11:0] rw;
        ng = !s ? adcmux_pkg::NEG_HALFREF : m[1] ? adcmux_pkg::NEG_GND
             : {1'b0, m[0], m[7:6]};
        rw = {ch, m[4:2], ng, 3'h0};
        if (m[1:0] == adcmux_pkg::MODE_DIFFGAIN && m[10:8] != 3'h7)
            rw[2:0] = m[10:8];
        if (b8) return {s ? {8{rw[7]}} : 8'h00, rw[7:0]};
        if (l) return {rw, 4'h0};
        return {s ? {4{rw[11]}} : 4'h0, rw};
    endfunction

    task automatic stop_test();
        if (err_total == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ========================================================================
    // Clock, watchdog and main sequence
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        `CHK(1'b0, 1'b1)
        stop_test();
    end

    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, evt_trig} = {1'b1, 47'h0};
        err_total = 0;
        num_checks = 0;
        for (int c = 0; c < 4; c++) exp_r[c] = 16'h0000;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        void'($urandom(32'h5E2DFD66));
        // Unsigned at reset with mux zero differential flags a config error.
        for (int a = 0; a <= 44; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            `CHK(q, a == 8 ? 32'(adcmux_pkg::PRESC_RST)
                 : {27'h0, a == 12, 4'h0})
        end
        apb(1'b0, 8'h30, 32'h0);
        `CHK({e, q}, {1'b1, 32'h0})
        apb(1'b1, 8'h05, 32'h1);
        `CHK(e, 1'b1)
        apb(1'b1, adcmux_pkg::OFS_RES0, 32'hFFFF);
        apb(1'b0, adcmux_pkg::OFS_RES0, 32'h0);
        `CHK(q, 32'h0)
        for (int it = 0; it < 40; it++) begin
            {sg, r8, lf, rf} = 5'($urandom);
            if (it == 0) {sg, r8, lf} = 3'b100;
            apb(1'b1, adcmux_pkg::OFS_CONFIG, {26'h0, rf, 1'b0, lf, r8, sg});
            `CHK({conv_signed, conv_ref}, {sg, rf})
            apb(1'b1, adcmux_pkg::OFS_PRESC, $urandom_range(0, 3));
            for (int c = 0; c < 4; c++) begin
                mux[c] = 12'($urandom);
                if (!sg) mux[c][1] = 1'b1;
                if (mux[c][1:0] == 2'h3) mux[c][5:4] = 2'h0;
                // Raw 0x800 in signed right-adjusted mode hits the low end.
                if (it == 0 && c == 2) mux[c] = 12'h000;
                apb(1'b1, adcmux_pkg::OFS_MUX0 + 8'(4 * c), {20'h0, mux[c]});
            end
            starts = 4'($urandom_range(1, 15));
            if (it == 0) starts[2] = 1'b1;
            evt = 4'($urandom) & ~starts;
            apb(1'b1, adcmux_pkg::OFS_CTRL, {24'h0, starts, 4'h0});
            apb(1'b0, adcmux_pkg::OFS_STATUS, 32'h0);
            `CHK({conv_en, q}, 33'h0)
            apb(1'b1, adcmux_pkg::OFS_CTRL, 32'h1);
            `CHK(conv_en, 1'b1)
            evt_trig <= evt;
            @(posedge clk);
            evt_trig <= 4'h0;
            exp_done = starts | (evt & {mux[3][11], mux[2][11], mux[1][11],
                                        mux[0][11]});
            n = 0;
            do begin
                apb(1'b0, adcmux_pkg::OFS_STATUS, 32'h0);
                n++;
            end while (q[3:0] !== exp_done && n < 50);
            `CHK(q[4:0], {1'b0, exp_done})
            for (int c = 0; c < 4; c++) begin
                if (exp_done[c]) exp_r[c] = exp_res(mux[c], 2'(c), sg, r8, lf);
                apb(1'b0, adcmux_pkg::OFS_RES0 + 8'(4 * c), 32'h0);
                `CHK(q, {16'h0, exp_r[c]})
            end
            apb(1'b1, adcmux_pkg::OFS_STATUS, 32'hF);
        end
        stop_test();
    end
endmodule // tb_adc_input_mux_result_format

`undef CHK
`default_nettype wire

//--- inc/adcmux_pkg.sv
// Package with the register map, field layout and encodings of the converter control.
//
// Notes on behaviour
// - Plain differential: any pin positive, pins 0 to 3 negative.
// - Differential with gain: any pin positive, pins 4 to 7 negative.
// - Gain factors are 1x, 2x, 4x, 8x, 16x, 32x and 64x only.
// - Single ended allowed in both modes; signed mode grounds the negative input.
// - Four internal sources: temperature, bandgap, supply over ten, DAC output.
// - Unsigned mode: negative input is half reference minus five percent offset.
// - Two converters split the ports; a single converter reaches both ports.
// - Four channels, each with mux control, result, trigger, event and flag.
// - One shared converter takes one start per converter clock; results stay apart.
// - Reference: internal 1.00 V, supply over 1.6, either port's reference pin.
// - Signed or unsigned is one global setting for all channels.
// - Signed 12-bit results span 0xF800 to 0x07FF.
// - Unsigned 12-bit results span zero to 0x0FFF.
// - Software picks 8-bit or 12-bit; 8-bit finishes sooner.
// - Results are 16 bits; 8-bit results sit right adjusted in the low byte.
// - A 12-bit result may be right or left adjusted.
// - Signed 12-bit right adjusted copies bit 11 into bits 12 to 15.
// - Signed 8-bit copies bit 7 across the high byte.
// - Signed result scales with gain, which is one unless gained differential.
package adcmux_pkg;

    // ========================================================================
    // Register offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CONFIG = 8'h04;
    localparam logic [7:0] OFS_PRESC  = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_MUX0   = 8'h10;
    localparam logic [7:0] OFS_RES0   = 8'h20;
    localparam logic [7:0] OFS_LAST   = 8'h2C;

    // ========================================================================
    // Field positions
    localparam int CTRL_ENABLE  = 0;
    localparam int CTRL_START   = 4;
    localparam int CFG_SIGNED   = 0;
    localparam int CFG_RES8     = 1;
    localparam int CFG_LEFT     = 2;
    localparam int CFG_REF      = 4;
    localparam int STAT_CFGERR  = 4;
    localparam int MUX_MODE     = 0;
    localparam int MUX_POS      = 2;
    localparam int MUX_NEG      = 6;
    localparam int MUX_GAIN     = 8;
    localparam int MUX_EVEN     = 11;
    localparam int MUX_W        = 12;

    // ========================================================================
    // Reset values
    localparam logic [7:0]        PRESC_RST = 8'h03;
    localparam logic [MUX_W-1:0]  MUX_RST   = 12'h000;
    localparam logic [15:0]       RES_RST   = 16'h0000;

    // ========================================================================
    // Encodings
    typedef enum logic [1:0] {
        MODE_DIFF, MODE_DIFFGAIN, MODE_SINGLE, MODE_INTERNAL
    } adcmux_mode_t;

    localparam logic [1:0] INT_TEMP    = 2'h0;
    localparam logic [1:0] INT_BANDGAP = 2'h1;
    localparam logic [1:0] INT_VCC10   = 2'h2;
    localparam logic [1:0] INT_DAC     = 2'h3;

    localparam logic [1:0] REF_INT1V0  = 2'h0;
    localparam logic [1:0] REF_VCC1P6  = 2'h1;
    localparam logic [1:0] REF_FIRST_ANALOG_PORT   = 2'h2;
    localparam logic [1:0] REF_SECOND_ANALOG_PORT   = 2'h3;

    localparam logic [3:0] NEG_GND     = 4'h8;
    localparam logic [3:0] NEG_HALFREF = 4'h9;
    localparam logic [3:0] NEG_GAINBASE = 4'h4;
    localparam logic [2:0] GAIN_MAX    = 3'h6;

    typedef struct packed {
        logic         start;
        logic [1:0]   chan;
        adcmux_mode_t mode;
        logic         pos_port;
        logic [2:0]   pos_pin;
        logic [3:0]   neg_sel;
        logic [2:0]   gain;
        logic         res8;
    } adcmux_conv_t;

endpackage

//--- verilog/adcmux_ctrl.sv
// Converter control: register file, channel arbitration and result formatting.
`timescale 1ns/1ps
`default_nettype none

module adcmux_ctrl #(
    parameter bit DUAL_CONV  = 1'b0,
    parameter bit INSTANCE_B = 1'b0
) (
    // Clock and reset
    input  wire logic                      CLOCK,
    input  wire logic                      RST,
    // APB slave
    input  wire logic                      PSEL,
    input  wire logic                      PENABLE,
    input  wire logic                      PWRITE,
    input  wire logic [7:0]                PADDR,
    input  wire logic [31:0]               PWDATA,
    output logic      [31:0]               PRDATA,
    output logic                           PREADY,
    output logic                           PSLVERR,
    // Event triggers, one per channel
    input  wire logic [3:0]                EVENT_TRIG,
    // Results from the converter core
    input  wire logic                      CORE_DONE,
    input  wire logic [1:0]                CORE_CHAN,
    input  wire logic [11:0]               CORE_RAW,
    // Settings to the converter core
    output adcmux_pkg::adcmux_conv_t       CONV,
    output logic                           CONV_ENABLE,
    output logic                           CONV_SIGNED,
    output logic [1:0]                     CONV_REF,
    output logic [3:0]                     RESULT_EVENT
);

    // ========================================================================
    // Result formatting
    function automatic logic [15:0] fmt_result(
        input logic [11:0] raw,
        input logic        sgn,
        input logic        res8,
        input logic        left
    );
        logic [15:0] r;
        r = 16'h0000;
        if (res8) begin
            r = {{8{sgn & raw[7]}}, raw[7:0]};
        end else if (left) begin
            r = {raw, 4'h0};
        end else begin
            r = {{4{sgn & raw[11]}}, raw};
        end
        return r;
    endfunction

    function automatic logic [1:0] first_one(input logic [3:0] v);
        logic [1:0] r;
        r = 2'h0;
        if (v[0]) begin
            r = 2'h0;
        end else if (v[1]) begin
            r = 2'h1;
        end else if (v[2]) begin
            r = 2'h2;
        end else if (v[3]) begin
            r = 2'h3;
        end
        return r;
    endfunction

    // ========================================================================
    // State
    logic                                  enable_ff;
    logic                                  signed_ff;
    logic                                  res8_ff;
    logic                                  left_ff;
    logic [1:0]                            ref_ff;
    logic [7:0]                            presc_ff;
    logic [7:0]                            div_ff;
    logic [3:0]                            pend_ff;
    logic [3:0]                            done_ff;
    logic [3:0]                            revt_ff;
    logic [adcmux_pkg::MUX_W-1:0]          mux_ff [4];
    logic [15:0]                           res_ff [4];
    logic [31:0]                           prdata_ff;
    logic                                  pready_ff;
    logic                                  pslverr_ff;
    adcmux_pkg::adcmux_conv_t              conv_ff;
    adcmux_pkg::adcmux_conv_t              nxt_conv;

    // ========================================================================
    // Bus decode
    wire logic        setup_ph  = PSEL & ~PENABLE;
    wire logic        access_ok = PSEL & PENABLE & pready_ff;
    wire logic        wr_en     = access_ok & PWRITE & ~pslverr_ff;
    wire logic        aligned   = (PADDR[1:0] == 2'b00);
    wire logic        mapped    = aligned & (PADDR <= adcmux_pkg::OFS_LAST);
    wire logic        wr_ctrl   = wr_en & (PADDR == adcmux_pkg::OFS_CTRL);
    wire logic        wr_cfg    = wr_en & (PADDR == adcmux_pkg::OFS_CONFIG);
    wire logic        wr_presc  = wr_en & (PADDR == adcmux_pkg::OFS_PRESC);
    wire logic        wr_stat   = wr_en & (PADDR == adcmux_pkg::OFS_STATUS);
    wire logic        in_mux    = (PADDR[7:4] == adcmux_pkg::OFS_MUX0[7:4]);
    wire logic        in_res    = (PADDR[7:4] == adcmux_pkg::OFS_RES0[7:4]);
    wire logic [1:0]  sel_ch    = PADDR[3:2];

    // ========================================================================
    // Converter clock enable and arbitration
    // The converter clock is a one-cycle enable; a start is only offered
    // on it, so the shared pipeline never sees two starts in one period.
    wire logic        conv_tick = enable_ff & (div_ff == presc_ff);
    wire logic [7:0]  nxt_div   = conv_tick ? 8'h00 : 8'(div_ff + 8'h01);
    wire logic [3:0]  sw_start  = wr_ctrl ? PWDATA[adcmux_pkg::CTRL_START +: 4]
                                          : 4'h0;
    wire logic [3:0]  evt_start;
    wire logic        grant     = conv_tick & (|pend_ff);
    wire logic [1:0]  gch       = first_one(pend_ff);
    wire logic [3:0]  gmask     = grant ? (4'h1 << gch) : 4'h0;
    wire logic [3:0]  core_hit  = CORE_DONE ? (4'h1 << CORE_CHAN) : 4'h0;
    wire logic [15:0] fmt_val   = fmt_result(CORE_RAW, signed_ff, res8_ff,
                                             left_ff);
    wire logic [3:0]  is_diff;

    // ========================================================================
    // Per-channel state
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_chan
            assign evt_start[g] = EVENT_TRIG[g] &
                                  mux_ff[g][adcmux_pkg::MUX_EVEN];
            assign is_diff[g] = ~mux_ff[g][adcmux_pkg::MUX_MODE + 1];

            always_ff @(posedge CLOCK or posedge RST) begin
                if (RST) begin
                    mux_ff[g]  <= adcmux_pkg::MUX_RST;
                    res_ff[g]  <= adcmux_pkg::RES_RST;
                    pend_ff[g] <= 1'b0;
                    done_ff[g] <= 1'b0;
                    revt_ff[g] <= 1'b0;
                end else begin
                    if (wr_en && in_mux && sel_ch == 2'(g)) begin
                        mux_ff[g] <= PWDATA[adcmux_pkg::MUX_W-1:0];
                    end
                    // A new trigger in the granting cycle is kept.
                    pend_ff[g] <= (pend_ff[g] & ~gmask[g]) |
                                  sw_start[g] | evt_start[g];
                    if (core_hit[g]) begin
                        res_ff[g] <= fmt_val;
                    end
                    // Set wins over a write-one clear in the same cycle.
                    done_ff[g] <= core_hit[g] |
                                  (done_ff[g] & ~(wr_stat & PWDATA[g]));
                    revt_ff[g] <= core_hit[g];
                end
            end
        end
    endgenerate

    // ========================================================================
    // Settings of the granted channel
    logic [adcmux_pkg::MUX_W-1:0] gmux;
    adcmux_pkg::adcmux_mode_t     gmode;
    logic [3:0]                   gpos;
    logic [1:0]                   gneg;
    logic [2:0]                   ggain;

    assign gmux  = mux_ff[gch];
    assign gmode = adcmux_pkg::adcmux_mode_t'(gmux[adcmux_pkg::MUX_MODE +: 2]);
    assign gpos  = gmux[adcmux_pkg::MUX_POS +: 4];
    assign gneg  = gmux[adcmux_pkg::MUX_NEG +: 2];
    assign ggain = gmux[adcmux_pkg::MUX_GAIN +: 3];

    always_comb begin
        nxt_conv          = conv_ff;
        nxt_conv.start    = grant;
        if (grant) begin
            nxt_conv.chan     = gch;
            nxt_conv.mode     = gmode;
            nxt_conv.res8     = res8_ff;
            // With two converters each reaches only its own port.
            nxt_conv.pos_port = DUAL_CONV ? INSTANCE_B : gpos[3];
            nxt_conv.pos_pin  = gpos[2:0];
            nxt_conv.gain     = 3'h0;
            nxt_conv.neg_sel  = adcmux_pkg::NEG_GND;
            if (gmode == adcmux_pkg::MODE_INTERNAL) begin
                nxt_conv.pos_pin = {1'b0, gpos[1:0]};
            end
            if (!signed_ff) begin
                nxt_conv.neg_sel = adcmux_pkg::NEG_HALFREF;
            end else begin
                case (gmode)
                    adcmux_pkg::MODE_DIFF: begin
                        nxt_conv.neg_sel = {2'b00, gneg};
                    end
                    adcmux_pkg::MODE_DIFFGAIN: begin
                        nxt_conv.neg_sel = adcmux_pkg::NEG_GAINBASE |
                                           {2'b00, gneg};
                        // Code seven is not a factor and falls back to 1x.
                        nxt_conv.gain = (ggain <= adcmux_pkg::GAIN_MAX) ?
                                        ggain : 3'h0;
                    end
                    adcmux_pkg::MODE_SINGLE: begin
                        nxt_conv.neg_sel = adcmux_pkg::NEG_GND;
                    end
                    adcmux_pkg::MODE_INTERNAL: begin
                        nxt_conv.neg_sel = adcmux_pkg::NEG_GND;
                    end
                    default: begin
                        nxt_conv.neg_sel = adcmux_pkg::NEG_GND;
                    end
                endcase
            end
        end
    end

    // ========================================================================
    // Read data
    // A differential channel in unsigned mode cannot be measured correctly,
    // so the conflict is shown to software instead of silently converted.
    wire logic cfg_err = ~signed_ff & (|is_diff);
    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h0000_0000;
        if (in_mux) begin
            rd_word = {20'h00000, mux_ff[sel_ch]};
        end else if (in_res) begin
            rd_word = {16'h0000, res_ff[sel_ch]};
        end else begin
            case (PADDR)
                adcmux_pkg::OFS_CTRL:   rd_word = {31'h0, enable_ff};
                adcmux_pkg::OFS_CONFIG: rd_word = {26'h0, ref_ff, 1'b0,
                                                   left_ff, res8_ff,
                                                   signed_ff};
                adcmux_pkg::OFS_PRESC:  rd_word = {24'h000000, presc_ff};
                adcmux_pkg::OFS_STATUS: rd_word = {27'h0, cfg_err, done_ff};
                default:                rd_word = 32'h0000_0000;
            endcase
        end
    end

    // ========================================================================
    // Global registers and bus answer
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            enable_ff  <= 1'b0;
            signed_ff  <= 1'b0;
            res8_ff    <= 1'b0;
            left_ff    <= 1'b0;
            ref_ff     <= adcmux_pkg::REF_INT1V0;
            presc_ff   <= adcmux_pkg::PRESC_RST;
            div_ff     <= 8'h00;
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                enable_ff <= PWDATA[adcmux_pkg::CTRL_ENABLE];
            end
            if (wr_cfg) begin
                signed_ff <= PWDATA[adcmux_pkg::CFG_SIGNED];
                res8_ff   <= PWDATA[adcmux_pkg::CFG_RES8];
                left_ff   <= PWDATA[adcmux_pkg::CFG_LEFT];
                ref_ff    <= PWDATA[adcmux_pkg::CFG_REF +: 2];
            end
            if (wr_presc) begin
                presc_ff <= PWDATA[7:0];
            end
            div_ff     <= enable_ff ? nxt_div : 8'h00;
            pready_ff  <= setup_ph;
            pslverr_ff <= setup_ph & ~mapped;
            if (setup_ph) begin
                prdata_ff <= rd_word;
            end
        end
    end

    // ========================================================================
    // Converter side outputs
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            conv_ff <= '0;
        end else begin
            conv_ff <= nxt_conv;
        end
    end

    assign PRDATA       = prdata_ff;
    assign PREADY       = pready_ff;
    assign PSLVERR      = pslverr_ff;
    assign CONV         = conv_ff;
    assign CONV_ENABLE  = enable_ff;
    assign CONV_SIGNED  = signed_ff;
    assign CONV_REF     = ref_ff;
    assign RESULT_EVENT = revt_ff;

endmodule // adcmux_ctrl

`default_nettype wire
